// [verilog/udb_uart.sv]
// serial data buffer with transmit fifo, baud timers and axi-lite slave
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - one data address: writes go to transmit, reads return receive latch
// - written byte sits in transmit shifter until fully shifted out
// - writing the data buffer starts transmission only while the run bit is set
// - prescale field picks clock/12, /4, /48 or external oscillator/8
// - direct clock bit set: timer runs on undivided clock, prescale ignored
// - tx and rx baud ticks are timer overflows halved, one shared reload
// - start edge on receive pin forces receive timer reload
module udb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;

    assign in_ready  = (wptr ^ rptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = wptr != rptr;
    assign out_data  = mem[rptr[AW-1:0]];

    always_ff @(posedge aclk) begin
        if (in_valid && in_ready) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wptr <= wptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
module udb_uart (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // axi4-lite write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    // axi4-lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    // serial pins and oscillator
    input  wire logic        external_oscillator_clock,
    input  wire logic        serial_rx,
    output logic             serial_tx
);
    function automatic logic [5:0] presc_div(input logic [1:0] sel);
        unique case (sel)
            udb_pkg::PSEL_DIV12: presc_div = udb_pkg::DIV_12;
            udb_pkg::PSEL_DIV4:  presc_div = udb_pkg::DIV_4;
            udb_pkg::PSEL_DIV48: presc_div = udb_pkg::DIV_48;
            udb_pkg::PSEL_EXT8:  presc_div = udb_pkg::DIV_EXT;
        endcase
    endfunction

    logic                    run;
    logic                    baud_timer_direct_clock_select;
    logic [1:0]              timer_prescale_select;
    logic [7:0]              baud_timer_reload_byte;
    logic                    have_aw;
    logic                    have_w;
    logic [7:0]              waddr;
    logic [31:0]             wdat;
    logic [3:0]              wstb;
    logic                    fifo_in_valid;
    logic                    fifo_in_ready;
    logic                    fifo_out_valid;
    logic                    fifo_out_ready;
    logic [7:0]              fifo_out_data;
    logic                    wr_go;
    logic                    ctrl_wr;
    logic                    data_rd;
    logic                    ext_q1;
    logic                    ext_q2;
    logic                    ext_q3;
    logic [5:0]              presc_cnt;
    logic                    presc_tick;
    logic                    timer_tick;
    logic [7:0]              baud_timer_count_byte;
    logic                    tx_half;
    logic                    tx_ovf;
    logic                    tx_baud;
    logic [7:0]              rx_cnt;
    logic                    rx_half;
    logic                    rx_ovf;
    logic                    rx_q1;
    logic                    rx_q2;
    logic                    rx_q3;
    logic                    start_det;
    udb_pkg::udb_state_t     tx_state;
    udb_pkg::udb_state_t     rx_state;
    logic [9:0]              tx_shift;
    logic [3:0]              tx_bits;
    logic [7:0]              rx_shift;
    logic [3:0]              rx_bits;
    logic [7:0]              serial_data_buffer;
    logic                    rx_full;

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer
    // data address write feeds transmit side
    assign wr_go = have_aw && have_w && !bvalid &&
                   (waddr != udb_pkg::ADDR_DATA || !wstb[0] || fifo_in_ready);
    assign fifo_in_valid = have_aw && have_w && !bvalid && wstb[0] &&
                           waddr == udb_pkg::ADDR_DATA;
    assign ctrl_wr = wr_go && waddr == udb_pkg::ADDR_CTRL;
    assign data_rd = arvalid && arready && araddr == udb_pkg::ADDR_DATA;
    assign fifo_out_ready = tx_state == udb_pkg::ST_IDLE && run;

    udb_fifo #(.WIDTH(udb_pkg::DATA_W), .DEPTH(udb_pkg::FIFO_DEPTH)) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (wdat[7:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            have_w  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            waddr   <= 8'h00;
            wdat    <= 32'h0000_0000;
            wstb    <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= udb_pkg::RESP_OKAY;
        end else begin
            awready <= !have_aw && !(awvalid && awready);
            wready  <= !have_w && !(wvalid && wready);
            if (awvalid && awready) begin
                have_aw <= 1'b1;
                waddr   <= awaddr;
            end
            if (wvalid && wready) begin
                have_w <= 1'b1;
                wdat   <= wdata;
                wstb   <= wstrb;
            end
            if (wr_go) begin
                have_aw <= 1'b0;
                have_w  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (waddr == udb_pkg::ADDR_DATA ||
                            waddr == udb_pkg::ADDR_CTRL ||
                            waddr == udb_pkg::ADDR_STAT) ?
                           udb_pkg::RESP_OKAY : udb_pkg::RESP_DECERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run                            <= udb_pkg::RUN_RST;
            baud_timer_direct_clock_select <= udb_pkg::DIRECT_RST;
            timer_prescale_select          <= udb_pkg::PSEL_RST;
            baud_timer_reload_byte         <= udb_pkg::RELOAD_RST;
        end else if (ctrl_wr) begin
            if (wstb[0]) begin
                run <= wdat[udb_pkg::CTRL_RUN];
                baud_timer_direct_clock_select <= wdat[udb_pkg::CTRL_DIRECT];
                timer_prescale_select <= wdat[udb_pkg::CTRL_PSEL +: 2];
            end
            if (wstb[1]) begin
                baud_timer_reload_byte <= wdat[udb_pkg::CTRL_RELOAD +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= udb_pkg::RESP_OKAY;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp  <= udb_pkg::RESP_OKAY;
                rdata  <= 32'h0000_0000;
                unique case (araddr)
                    // data address read returns receive latch
                    udb_pkg::ADDR_DATA: rdata[7:0] <= serial_data_buffer;
                    udb_pkg::ADDR_CTRL: begin
                        rdata[udb_pkg::CTRL_RUN]    <= run;
                        rdata[udb_pkg::CTRL_DIRECT] <=
                            baud_timer_direct_clock_select;
                        rdata[udb_pkg::CTRL_PSEL +: 2] <=
                            timer_prescale_select;
                        rdata[udb_pkg::CTRL_RELOAD +: 8] <=
                            baud_timer_reload_byte;
                    end
                    udb_pkg::ADDR_STAT: begin
                        rdata[udb_pkg::STAT_BUSY] <=
                            tx_state == udb_pkg::ST_BUSY || fifo_out_valid;
                        rdata[udb_pkg::STAT_RXFULL] <= rx_full;
                        rdata[udb_pkg::STAT_FFULL]  <= !fifo_in_ready;
                        rdata[udb_pkg::STAT_FEMPTY] <= !fifo_out_valid;
                    end
                    default: rresp <= udb_pkg::RESP_DECERR;
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud timer clock select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_q1 <= 1'b0;
            ext_q2 <= 1'b0;
            ext_q3 <= 1'b0;
        end else begin
            ext_q1 <= external_oscillator_clock;
            ext_q2 <= ext_q1;
            ext_q3 <= ext_q2;
        end
    end

    // prescaler counts clocks or oscillator edges
    always_ff @(posedge aclk) begin
        if (!aresetn || ctrl_wr) begin
            presc_cnt <= 6'h00;
        end else if (timer_prescale_select != udb_pkg::PSEL_EXT8 ||
                     (ext_q2 && !ext_q3)) begin
            presc_cnt <= presc_tick ? 6'h00 : presc_cnt + 6'h01;
        end
    end
    assign presc_tick = presc_cnt == presc_div(timer_prescale_select) - 6'h01
                        && (timer_prescale_select != udb_pkg::PSEL_EXT8 ||
                            (ext_q2 && !ext_q3));
    assign timer_tick = run && (baud_timer_direct_clock_select || presc_tick);

    ////////////////////////////////////////////////////////////////////////
    // auto-reload timers, overflows halved
    assign tx_ovf  = timer_tick && baud_timer_count_byte == udb_pkg::TIMER_TOP;
    assign rx_ovf  = timer_tick && rx_cnt == udb_pkg::TIMER_TOP;
    assign tx_baud = tx_ovf && tx_half;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_timer_count_byte <= 8'h00;
            tx_half               <= 1'b0;
        end else if (tx_ovf) begin
            baud_timer_count_byte <= baud_timer_reload_byte;
            tx_half               <= !tx_half;
        end else if (timer_tick) begin
            baud_timer_count_byte <= baud_timer_count_byte + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_cnt  <= 8'h00;
            rx_half <= 1'b0;
        end else if (start_det) begin
            rx_cnt  <= baud_timer_reload_byte;
            rx_half <= 1'b0;
        end else if (rx_ovf) begin
            rx_cnt  <= baud_timer_reload_byte;
            rx_half <= !rx_half;
        end else if (timer_tick) begin
            rx_cnt <= rx_cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state  <= udb_pkg::ST_IDLE;
            tx_shift  <= 10'h3ff;
            tx_bits   <= 4'h0;
            serial_tx <= 1'b1;
        end else begin
            serial_tx <= tx_state == udb_pkg::ST_BUSY ? tx_shift[0] : 1'b1;
            unique case (tx_state)
                udb_pkg::ST_IDLE: begin
                    if (fifo_out_valid && fifo_out_ready) begin
                        tx_shift <= {1'b1, fifo_out_data, 1'b0};
                        tx_bits  <= 4'h0;
                        tx_state <= udb_pkg::ST_BUSY;
                    end
                end
                udb_pkg::ST_BUSY: begin
                    // hold byte until last bit is out
                    if (tx_baud) begin
                        tx_shift <= {1'b1, tx_shift[9:1]};
                        tx_bits  <= tx_bits + 4'h1;
                        if (tx_bits == udb_pkg::LAST_BIT) begin
                            tx_state <= udb_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_q1 <= 1'b1;
            rx_q2 <= 1'b1;
            rx_q3 <= 1'b1;
        end else begin
            rx_q1 <= serial_rx;
            rx_q2 <= rx_q1;
            rx_q3 <= rx_q2;
        end
    end
    assign start_det = run && rx_state == udb_pkg::ST_IDLE && rx_q3 && !rx_q2;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state           <= udb_pkg::ST_IDLE;
            rx_shift           <= 8'h00;
            rx_bits            <= 4'h0;
            serial_data_buffer <= 8'h00;
            rx_full            <= 1'b0;
        end else begin
            if (data_rd) begin
                rx_full <= 1'b0;
            end
            unique case (rx_state)
                udb_pkg::ST_IDLE: begin
                    if (start_det) begin
                        rx_bits  <= 4'h0;
                        rx_state <= udb_pkg::ST_BUSY;
                    end
                end
                udb_pkg::ST_BUSY: begin
                    if (rx_ovf && !rx_half) begin
                        rx_bits  <= rx_bits + 4'h1;
                        rx_shift <= {rx_q2, rx_shift[7:1]};
                        if (rx_bits == 4'h0 && rx_q2) begin
                            rx_state <= udb_pkg::ST_IDLE;
                        end
                        if (rx_bits == udb_pkg::LAST_BIT) begin
                            rx_shift           <= rx_shift;
                            serial_data_buffer <= rx_shift;
                            rx_full            <= 1'b1;
                            rx_state           <= udb_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_rd_latch;
        @(posedge aclk) disable iff (!aresetn)
        data_rd |=> rdata[7:0] == $past(serial_data_buffer) && rvalid;
    endproperty
    a_rd_latch: assert property (p_rd_latch) else $error("bad data read");

    property p_tx_hold;
        @(posedge aclk) disable iff (!aresetn)
        tx_state == udb_pkg::ST_BUSY && !tx_baud |=> $stable(tx_shift);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost");

    property p_tx_start;
        @(posedge aclk) disable iff (!aresetn)
        fifo_out_valid && fifo_out_ready |=>
            tx_state == udb_pkg::ST_BUSY ##1 !serial_tx;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no tx start");

    property p_div4;
        @(posedge aclk) disable iff (!aresetn || ctrl_wr)
        presc_tick && timer_prescale_select == udb_pkg::PSEL_DIV4 |=>
            !presc_tick [*3] ##1 presc_tick;
    endproperty
    a_div4: assert property (p_div4) else $error("bad div4 spacing");

    property p_direct;
        @(posedge aclk) disable iff (!aresetn)
        run && baud_timer_direct_clock_select && !tx_ovf |=>
            baud_timer_count_byte == $past(baud_timer_count_byte) + 8'h01;
    endproperty
    a_direct: assert property (p_direct) else $error("direct not ticking");

    property p_tx_reload;
        @(posedge aclk) disable iff (!aresetn)
        tx_ovf |=> baud_timer_count_byte == $past(baud_timer_reload_byte)
                   && tx_half != $past(tx_half);
    endproperty
    a_tx_reload: assert property (p_tx_reload) else $error("bad reload");

    property p_rx_force;
        @(posedge aclk) disable iff (!aresetn)
        start_det |=> rx_cnt == $past(baud_timer_reload_byte) && !rx_half;
    endproperty
    a_rx_force: assert property (p_rx_force) else $error("no rx reload");

    c_tx_frame: cover property (@(posedge aclk) disable iff (!aresetn)
        tx_state == udb_pkg::ST_BUSY ##1 tx_state == udb_pkg::ST_IDLE);
    c_rx_byte: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(rx_full));
    c_fifo_full: cover property (@(posedge aclk) disable iff (!aresetn)
        !fifo_in_ready);
endmodule
`default_nettype wire

// [inc/udb_pkg.sv]
// constants for the serial data buffer and baud clock select block
package udb_pkg;
    // register byte addresses
    localparam logic [7:0]  ADDR_DATA     = 8'h00;
    localparam logic [7:0]  ADDR_CTRL     = 8'h04;
    localparam logic [7:0]  ADDR_STAT     = 8'h08;
    // control field positions
    localparam int          CTRL_RUN      = 0;
    localparam int          CTRL_DIRECT   = 1;
    localparam int          CTRL_PSEL     = 2;
    localparam int          CTRL_RELOAD   = 8;
    // control reset values
    localparam logic        RUN_RST       = 1'b0;
    localparam logic        DIRECT_RST    = 1'b0;
    localparam logic [1:0]  PSEL_RST      = 2'h0;
    localparam logic [7:0]  RELOAD_RST    = 8'h00;
    // status field positions
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_RXFULL   = 1;
    localparam int          STAT_FFULL    = 2;
    localparam int          STAT_FEMPTY   = 3;
    // prescale select codes and divide ratios
    localparam logic [1:0]  PSEL_DIV12    = 2'h0;
    localparam logic [1:0]  PSEL_DIV4     = 2'h1;
    localparam logic [1:0]  PSEL_DIV48    = 2'h2;
    localparam logic [1:0]  PSEL_EXT8     = 2'h3;
    localparam logic [5:0]  DIV_12        = 6'h0c;
    localparam logic [5:0]  DIV_4         = 6'h04;
    localparam logic [5:0]  DIV_48        = 6'h30;
    localparam logic [5:0]  DIV_EXT       = 6'h08;
    // frame and buffer shape
    localparam int          DATA_W        = 8;
    localparam int          FIFO_DEPTH    = 32;
    localparam logic [3:0]  LAST_BIT      = 4'h9;
    localparam logic [7:0]  TIMER_TOP     = 8'hff;
    // bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_DECERR   = 2'h3;
    // one-hot engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } udb_state_t;
endpackage

// [verif/udb_remote.sv]
// remote serial transceiver model facing the data buffer block
`timescale 1ns/100ps
`default_nettype none
module udb_remote (
    // clock
    input  wire logic aclk,
    // serial pins
    input  wire logic serial_tx,
    output var logic  serial_rx
);
    initial serial_rx = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // frame a byte onto the receive line, lsb first, t cycles a bit
    task automatic send(input logic [7:0] b, input int t);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            serial_rx <= f[i];
            repeat (t - 1) @(posedge aclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // catch a frame; start length may vary, so data bit 0 must be 1
    task automatic take(input int t, output logic [7:0] b,
                        output logic stp);
        int n;
        b = 'x;
        stp = 1'bx;
        n = 0;
        while (serial_tx !== 1'b0 && n < 30000) begin
            @(posedge aclk);
            n++;
        end
        while (serial_tx !== 1'b1 && n < 30000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 30000)
            return;
        repeat (t / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            b[i] = serial_tx;
            repeat (t) @(posedge aclk);
        end
        stp = serial_tx;
    endtask
endmodule
`default_nettype wire

// [verif/udb_uart_tb_top.sv]
// self-checking bench for the serial data buffer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected at %0t got %h expected %h", \
    $time, g, e); end end
module udb_uart_tb_top;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, serial_rx;
    logic        serial_tx, external_oscillator_clock;
    logic [7:0]  awaddr, araddr, got;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        stp;
    int          miscompares, comparisons, ext_cnt;
    localparam logic [7:0] RLD = 8'hfc;

    udb_uart uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .external_oscillator_clock, .serial_rx, .serial_tx);
    udb_remote rem (.aclk, .serial_tx, .serial_rx);

    always #25 aclk = ~aclk;
    // oscillator at a quarter of the bus clock
    always @(posedge aclk) begin
        ext_cnt <= ext_cnt + 1;
        if (ext_cnt[0])
            external_oscillator_clock <= ~external_oscillator_clock;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] cw(logic run, logic dir, logic [1:0] p);
        return (32'(RLD) << udb_pkg::CTRL_RELOAD)
            | (32'(p) << udb_pkg::CTRL_PSEL)
            | (32'(dir) << udb_pkg::CTRL_DIRECT)
            | (32'(run) << udb_pkg::CTRL_RUN);
    endfunction
    // bus cycles per serial bit
    function automatic int bt(logic dir, logic [1:0] p);
        int dv;
        case (p)
            udb_pkg::PSEL_DIV12: dv = int'(udb_pkg::DIV_12);
            udb_pkg::PSEL_DIV4:  dv = int'(udb_pkg::DIV_4);
            udb_pkg::PSEL_DIV48: dv = int'(udb_pkg::DIV_48);
            default:             dv = 4 * int'(udb_pkg::DIV_EXT);
        endcase
        if (dir)
            dv = 1;
        return 2 * (256 - int'(RLD)) * dv;
    endfunction

    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        $display("wait limit reached at %0t", $time);
        summarize();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [1:0] rs);
        int n;
        n = 0;
        rs = 'x;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        bready <= 1'b1;
        while (n < 3000) begin
            @(posedge aclk);
            n++;
            if (bvalid === 1'b1) begin
                rs = bresp;
                break;
            end
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (n >= 3000)
            hang();
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        d = 'x;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        while (n < 3000) begin
            @(posedge aclk);
            n++;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                break;
            end
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (n >= 3000)
            hang();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(udb_pkg::ADDR_CTRL);
        `CHK(d, 32'h0)
        `CHK(r, udb_pkg::RESP_OKAY)
        wr(udb_pkg::ADDR_DATA, 32'h77, 4'he, r);
        wr(udb_pkg::ADDR_STAT, 32'hf, 4'hf, r);
        `CHK(r, udb_pkg::RESP_OKAY)
        rd(udb_pkg::ADDR_STAT);
        `CHK(d, 32'h8)
        wr(8'h0c, 32'h1, 4'hf, r);
        `CHK(r, udb_pkg::RESP_DECERR)
        rd(8'h0c);
        `CHK(r, udb_pkg::RESP_DECERR)
        $display("register test done");
    endtask
    // prescale codes and direct clock, each with its own bit time
    task automatic t_modes;
        logic [7:0] b;
        for (int i = 0; i < 6; i++) begin
            b = 8'ha5 ^ 8'(i << 1);
            wr(udb_pkg::ADDR_CTRL, cw(1'b1, i > 3, 2'(i ^ 6)), 4'hf, r);
            fork
                rem.take(bt(i > 3, 2'(i ^ 6)), got, stp);
                wr(udb_pkg::ADDR_DATA, {24'h0, b}, 4'hf, r);
            join
            `CHK(got, b)
            `CHK(stp, 1'b1)
        end
        $display("clock select test done");
    endtask
    // receive start lands at any phase of the transmit timer
    task automatic t_duplex;
        wr(udb_pkg::ADDR_CTRL, cw(1'b1, 1'b1, 2'h2), 4'hf, r);
        fork
            rem.take(bt(1'b1, 2'h2), got, stp);
            wr(udb_pkg::ADDR_DATA, 32'h5b, 4'hf, r);
            rem.send(8'h3c, bt(1'b1, 2'h2));
        join
        `CHK(got, 8'h5b)
        rd(udb_pkg::ADDR_STAT);
        `CHK(d[udb_pkg::STAT_RXFULL], 1'b1)
        rd(udb_pkg::ADDR_DATA);
        `CHK(d, 32'h3c)
        rd(udb_pkg::ADDR_STAT);
        `CHK(d[udb_pkg::STAT_RXFULL], 1'b0)
        $display("duplex test done");
    endtask
    task automatic t_fifo;
        wr(udb_pkg::ADDR_CTRL, cw(1'b0, 1'b1, 2'h0), 4'hf, r);
        for (int i = 0; i < udb_pkg::FIFO_DEPTH; i++)
            wr(udb_pkg::ADDR_DATA, 32'(2 * i + 1), 4'hf, r);
        rd(udb_pkg::ADDR_STAT);
        `CHK(d, 32'h5)
        fork
            for (int i = 0; i < udb_pkg::FIFO_DEPTH; i++) begin
                rem.take(bt(1'b1, 2'h0), got, stp);
                `CHK(got, 8'(2 * i + 1))
            end
            wr(udb_pkg::ADDR_CTRL, cw(1'b1, 1'b1, 2'h0), 4'hf, r);
        join
        for (int n = 0; n < 20; n++) begin
            rd(udb_pkg::ADDR_STAT);
            if (d[udb_pkg::STAT_BUSY] === 1'b0)
                break;
        end
        `CHK(d, 32'h8)
        $display("buffer test done");
    endtask

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, ext_cnt} = '0;
        {miscompares, comparisons, external_oscillator_clock} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modes();
        t_duplex();
        t_fifo();
        summarize();
    end
endmodule
`default_nettype wire
